//--- src/pci_err_mode_pkg.sv
// Purpose: Shared constants for the bus error and mode control block
// Assumes: Core clock 100 MHz, bus clock sampled as a plain input
// Notes: Cycle counts are in bus clock edges unless named otherwise
package pci_err_mode_pkg;
    localparam int CORE_CLK_MHZ = 100;        // Core clock rate
    localparam int AD_WIDTH = 32;             // Address/data lines
    localparam int CBE_WIDTH = 4;             // Command/byte enable lines
    localparam int SERR_DELAY = 2;            // Bus edges from address to system error
    localparam int CLK_DIV_33 = 2;            // Core cycles per half period of the 25 MHz clock out
    localparam logic RST_HALTED = 1'b0;       // Not halted after reset
endpackage

//--- src/pci_bridge_error_mode_ctrl.sv
// Purpose: Parity error, system error, mode select, clock out and wake signalling
// Assumes: Bus clock arrives as a pin and is sampled by core_clk; bus pins synchronised
// Notes: Parity is checked on the sampled bus lines at each bus rising edge in an address or check phase
`timescale 1ns/10ps
module pci_bridge_error_mode_ctrl
    import pci_err_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic bus_clk,                    // Bus clock pin, sampled
    input wire logic [AD_WIDTH-1:0] ad_in,       // Address/data lines
    input wire logic [CBE_WIDTH-1:0] cbe_in,     // Command/byte enables
    input wire logic par_in,                     // Parity line
    input wire logic addr_phase,                 // Address phase strobe
    input wire logic check_phase,                // Local check of a data phase
    input wire logic drive_par,                  // Local logic drives parity output
    input wire logic is_master,                  // Local logic is bus master
    input wire logic burst_done,                 // Current burst finished
    input wire logic perr_n_in,                  // Parity error line level
    input wire logic host_clear_serr,            // Host clears error flags, halt and wake
    input wire logic m66en_in,                   // 66 MHz enable pin
    input wire logic bridge_mode_select,         // High host, low guest
    input wire logic wake_event,                 // Wake-up event, core domain
    input wire logic mini_card_active_n_in,      // Activity line level
    input wire logic clkrun_n_in,                // Clock run request line
    output logic perr_n_out,
    output logic perr_n_oe,
    output logic serr_n_out,
    output logic serr_n_oe,
    output logic pme_n_out,
    output logic pme_n_oe,
    output logic clkrun_n_oe,
    output logic bus_clock_out_primary,
    output logic bus_clock_out_second,
    output logic bus_clock_out_third,
    output logic bus_clock_out_fourth,
    output logic arbiter_enable,
    output logic host_mode,
    output logic bus_is_66,
    output logic clock_request,
    output logic mini_card_busy,
    output logic master_err_flag,
    output logic target_err_seen,
    output logic halted
);
    // Inputs from the bus domain pass two flip-flops
    localparam int SW = AD_WIDTH + CBE_WIDTH + 10;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    wire [SW-1:0] raw_in = {bus_clk, ad_in, cbe_in, par_in, addr_phase, check_phase,
        drive_par, is_master, burst_done, perr_n_in, m66en_in, bridge_mode_select};
    logic clkrun_s1;
    logic clkrun_s2;
    logic mini_s1;
    logic mini_s2;

    // Double flop synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            clkrun_s1 <= 1'b1;
            clkrun_s2 <= 1'b1;
            mini_s1 <= 1'b1;
            mini_s2 <= 1'b1;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            clkrun_s1 <= clkrun_n_in;
            clkrun_s2 <= clkrun_s1;
            mini_s1 <= mini_card_active_n_in;
            mini_s2 <= mini_s1;
        end
    end

    // Named views of synchronised bus lines
    wire s_clk = sync2[SW-1];
    wire [AD_WIDTH-1:0] s_ad = sync2[SW-2 -: AD_WIDTH];
    wire [CBE_WIDTH-1:0] s_cbe = sync2[9 +: CBE_WIDTH];
    wire s_par = sync2[8];
    wire s_addr = sync2[7];
    wire s_check = sync2[6];
    wire s_drive = sync2[5];
    wire s_master = sync2[4];
    wire s_done = sync2[3];
    wire s_perr_n = sync2[2];
    wire s_m66 = sync2[1];
    wire s_mode = sync2[0];

    logic clk_prev;                              // Last sampled bus clock
    wire bus_rise = s_clk & ~clk_prev;           // Rising edge of bus clock
    wire parity_bad = ^{s_ad, s_cbe, s_par};     // Even parity mismatch
    wire local_err = bus_rise & (s_check | s_addr) & parity_bad;
    wire remote_err = bus_rise & s_drive & ~s_perr_n;
    wire addr_err = bus_rise & s_addr & parity_bad;
    logic [SERR_DELAY-1:0] serr_pipe;            // Address error delay line
    logic burst_open;                            // Error seen, burst still running
    logic [1:0] div_cnt;                         // Clock out divider
    logic div_clk;                               // Generated bus clock

    // Edge finder
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) clk_prev <= 1'b0;
        else clk_prev <= s_clk;
    end

    // Parity error drive, one bus clock wide
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_n_oe <= 1'b0;
        end else if (bus_rise) begin
            perr_n_oe <= local_err;
        end
    end
    assign perr_n_out = 1'b0;

    // System error two bus edges after failing address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serr_pipe <= '0;
            serr_n_oe <= 1'b0;
        end else if (bus_rise) begin
            serr_pipe <= {serr_pipe[SERR_DELAY-2:0], addr_err};
            serr_n_oe <= serr_pipe[SERR_DELAY-1];
        end
    end
    assign serr_n_out = 1'b0;

    // Master error flag, halt after burst, resume on host clear
    wire master_err = (local_err | remote_err) & s_master;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            master_err_flag <= 1'b0;
            burst_open <= 1'b0;
            halted <= RST_HALTED;
        end else begin
            if (master_err) begin
                master_err_flag <= 1'b1;         // Set wins over clear
                burst_open <= 1'b1;
            end else if (host_clear_serr) begin
                master_err_flag <= 1'b0;
            end
            if (burst_open && bus_rise && s_done) begin
                burst_open <= master_err;
                halted <= 1'b1;
            end else if (halted && host_clear_serr && !master_err) begin
                halted <= 1'b0;
            end
        end
    end

    // Target side error reported by receiver
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) target_err_seen <= 1'b0;
        else if (remote_err) target_err_seen <= 1'b1;
        else if (host_clear_serr) target_err_seen <= 1'b0;
    end

    // Clock out divider, core rate over 2*CLK_DIV_33 gives 25 MHz
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
            div_clk <= 1'b0;
        end else if (div_cnt == 2'(CLK_DIV_33 - 1)) begin
            div_cnt <= '0;
            div_clk <= ~div_clk;
        end else begin
            div_cnt <= div_cnt + 2'd1;
        end
    end

    // Mode, clock outputs and status levels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_mode <= 1'b0;
            arbiter_enable <= 1'b0;
            bus_clock_out_primary <= 1'b0;
            bus_clock_out_second <= 1'b0;
            bus_clock_out_third <= 1'b0;
            bus_clock_out_fourth <= 1'b0;
            bus_is_66 <= 1'b0;
        end else begin
            host_mode <= s_mode;
            arbiter_enable <= s_mode;
            bus_clock_out_primary <= s_mode & div_clk;
            bus_clock_out_second <= s_mode & div_clk;
            bus_clock_out_third <= s_mode & div_clk;
            bus_clock_out_fourth <= s_mode & div_clk;
            bus_is_66 <= s_m66;
        end
    end

    // Side lines: clock run is input only, wake pulls power line
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_request <= 1'b0;
            mini_card_busy <= 1'b0;
            pme_n_oe <= 1'b0;
            clkrun_n_oe <= 1'b0;
        end else begin
            clock_request <= ~clkrun_s2;
            mini_card_busy <= ~mini_s2;
            clkrun_n_oe <= 1'b0;
            if (wake_event) pme_n_oe <= 1'b1;
            else if (host_clear_serr) pme_n_oe <= 1'b0;
        end
    end
    assign pme_n_out = 1'b0;

    // Checks
    serr_timing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_rise && s_addr && parity_bad |-> ##[1:100] serr_n_oe)
        else $error("system error not raised");
    perr_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        local_err |=> perr_n_oe)
        else $error("parity error not driven");
    halt_resume_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        halted && !host_clear_serr |=> halted)
        else $error("left halt without clear");
    master_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        master_err |=> master_err_flag)
        else $error("master error flag missing");
    remote_seen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        remote_err |=> target_err_seen)
        else $error("remote parity error missed");
    clkrun_never_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clkrun_n_oe)
        else $error("clock run driven");
    guest_clock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !host_mode ##1 !host_mode |-> !bus_clock_out_primary && !arbiter_enable)
        else $error("guest mode clock or arbiter active");
    wake_pull_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wake_event |=> pme_n_oe)
        else $error("wake not signalled");
    cov_addr_err: cover property (@(posedge core_clk) disable iff (!rst_n) serr_n_oe);
    cov_halt: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(halted));
    cov_host: cover property (@(posedge core_clk) disable iff (!rst_n) host_mode);
endmodule

//--- bench/bus_agent.sv
// Purpose: Far-side bus agent making the bus clock and the bus phases
// Assumes: Bus clock runs free, lines change on its falling edge
// Notes: Released lines show the inverse of their last value; error line idles high
`timescale 1ns/10ps
module bus_agent
    import pci_err_mode_pkg::*;
(
    output logic bus_clk,
    output logic [AD_WIDTH-1:0] ad_in,
    output logic [CBE_WIDTH-1:0] cbe_in,
    output logic par_in,
    output logic addr_phase,
    output logic check_phase,
    output logic drive_par,
    output logic burst_done,
    output logic perr_n_in
);
    // Lines start released, strobes idle
    initial begin
        bus_clk = 1'b0;
        {ad_in, cbe_in, par_in} = '0;
        {addr_phase, check_phase, drive_par, burst_done} = 4'h0;
        perr_n_in = 1'b1;
        // Bus clock, 125 ns period, edges kept off the core clock edges
        #1;
        forever #62.5 bus_clk = ~bus_clk;
    end
    // One bus phase held over one rising edge, then released
    task automatic send(input logic [31:0] a, input logic [3:0] c,
                        input logic bad, adr, chk, drv, done, rep);
        @(negedge bus_clk);
        ad_in = a;
        cbe_in = c;
        par_in = ^{a, c} ^ bad;
        {addr_phase, check_phase, drive_par, burst_done} = {adr, chk, drv, done};
        perr_n_in = ~rep;
        @(negedge bus_clk);
        ad_in = ~ad_in;
        cbe_in = ~cbe_in;
        par_in = ~par_in;
        {addr_phase, check_phase, drive_par, burst_done} = 4'h0;
        perr_n_in = 1'b1;
    endtask
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the bus error and mode control block
// Assumes: Core clock 100 MHz, bus agent model on the far side
// Notes: Bus phase checks land 63 to 63.5 ns after a bus rise, others 1 ns after a core edge, clear of core clock edges
`timescale 1ns/10ps
module testbench;
    import pci_err_mode_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, is_master = 1'b0, host_clear_serr = 1'b0;
    logic m66en_in = 1'b0, bridge_mode_select = 1'b0, wake_event = 1'b0;
    logic mini_card_active_n_in = 1'b1, clkrun_n_in = 1'b1;
    logic bus_clk, par_in, addr_phase, check_phase, drive_par, burst_done, perr_n_in;
    logic [AD_WIDTH-1:0] ad_in;
    logic [CBE_WIDTH-1:0] cbe_in;
    logic perr_n_out, perr_n_oe, serr_n_out, serr_n_oe, pme_n_out, pme_n_oe, clkrun_n_oe;
    logic bus_clock_out_primary, bus_clock_out_second, bus_clock_out_third;
    logic bus_clock_out_fourth, arbiter_enable, host_mode, bus_is_66, clock_request;
    logic mini_card_busy, master_err_flag, target_err_seen, halted;
    int n_errors = 0;
    int comparisons = 0;
    // Core clock
    always #5 core_clk = ~core_clk;
    bus_agent partner_u (.bus_clk, .ad_in, .cbe_in, .par_in, .addr_phase, .check_phase,
        .drive_par, .burst_done, .perr_n_in);
    pci_bridge_error_mode_ctrl dut_u (.core_clk, .rst_n, .bus_clk, .ad_in, .cbe_in,
        .par_in, .addr_phase, .check_phase, .drive_par, .is_master, .burst_done,
        .perr_n_in, .host_clear_serr, .m66en_in, .bridge_mode_select, .wake_event,
        .mini_card_active_n_in, .clkrun_n_in, .perr_n_out, .perr_n_oe, .serr_n_out,
        .serr_n_oe, .pme_n_out, .pme_n_oe, .clkrun_n_oe, .bus_clock_out_primary,
        .bus_clock_out_second, .bus_clock_out_third, .bus_clock_out_fourth,
        .arbiter_enable, .host_mode, .bus_is_66, .clock_request, .mini_card_busy,
        .master_err_flag, .target_err_seen, .halted);
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Wait core cycles, land just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Verdict and end of run
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Host clear pulse from the core side
    task automatic clear_pulse();
        host_clear_serr = 1'b1;
        cyc(1);
        host_clear_serr = 1'b0;
        cyc(3);
    endtask
    // Mode select and clock outputs; counts toggles over 12 core cycles
    task automatic t_mode(input logic sel, input int toggles);
        logic last;
        int n;
        bridge_mode_select = sel;
        cyc(6);
        check({host_mode, arbiter_enable}, {2{sel}});
        n = 0;
        last = bus_clock_out_primary;
        repeat (12) begin
            cyc(1);
            n += (bus_clock_out_primary !== last);
            last = bus_clock_out_primary;
            check({bus_clock_out_second, bus_clock_out_third, bus_clock_out_fourth},
                {3{last}});
        end
        check(n, toggles);
    endtask
    // Local parity check, good then bad
    task automatic t_parity();
        partner_u.send(32'ha5a5_0f0f, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        #1 check(perr_n_oe, 1'b0);
        partner_u.send(32'h0000_0001, 4'hf, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        #1 check({perr_n_oe, perr_n_out}, 2'b10);
    endtask
    // Address parity fault: system error two bus rises later, one bus clock long
    task automatic t_serr();
        partner_u.send(32'h1234_5678, 4'h6, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge bus_clk) #63 check(serr_n_oe, 1'b0);
        @(posedge bus_clk) #63 check({serr_n_oe, serr_n_out}, 2'b10);
        @(posedge bus_clk) #63 check(serr_n_oe, 1'b0);
    endtask
    // Reported error, master error, finish burst, halt, host clear
    task automatic t_master();
        partner_u.send(32'hffff_0000, 4'h7, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        #1 check(target_err_seen, 1'b1);
        cyc(1);
        is_master = 1'b1;
        partner_u.send(32'h8000_0000, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        #1 check({master_err_flag, halted}, 2'b10);
        partner_u.send(32'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        #1 check(halted, 1'b1);
        cyc(20);
        check(halted, 1'b1);
        clear_pulse();
        check({halted, master_err_flag, target_err_seen}, 3'h0);
        is_master = 1'b0;
    endtask
    // Plain pin levels and wake signalling
    task automatic t_pins();
        m66en_in = 1'b1;
        clkrun_n_in = 1'b0;
        mini_card_active_n_in = 1'b0;
        wake_event = 1'b1;
        cyc(1);
        wake_event = 1'b0;
        cyc(6);
        check(bus_is_66, 1'b1);
        check({clock_request, clkrun_n_oe}, 2'b10);
        check(mini_card_busy, 1'b1);
        check({pme_n_oe, pme_n_out}, 2'b10);
        clear_pulse();
        check(pme_n_oe, 1'b0);
    endtask
    // Main sequence
    initial begin
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        check({perr_n_oe, serr_n_oe, pme_n_oe, clkrun_n_oe, halted}, 5'h0);
        t_mode(1'b1, 12 / CLK_DIV_33);
        t_mode(1'b0, 0);
        t_parity();
        t_serr();
        t_master();
        t_pins();
        complete_run();
    end
    // Hang guard
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule
